// File: inc/adccal_regs.svh
// register offsets, reset values and timing counts of the calibration coefficient block
`ifndef ADCCAL_REGS_SVH
`define ADCCAL_REGS_SVH
`define ADCCAL_TOFF_ADDR 32'hffff0538
`define ADCCAL_IGAIN_ADDR 32'hffff053c
`define ADCCAL_STAT_ADDR 32'hffff0560
`define ADCCAL_TOFF_RST 16'h8000
`define ADCCAL_IGAIN_RST 16'h5555
`define ADCCAL_IDLE_NS 23000
`define ADCCAL_CLK_MHZ 25
`define ADCCAL_IDLE_CYC ((`ADCCAL_IDLE_NS * `ADCCAL_CLK_MHZ + 999) / 1000)
`define ADCCAL_STAT_OPEN_BIT 0
`define ADCCAL_STAT_EN_BIT 1
`define ADCCAL_STAT_IDLE_BIT 2
`define ADCCAL_STAT_DROP_BIT 3
`endif

// File: inc/adccal_pkg.sv
// types shared by the calibration coefficient block
package adccal_pkg;
   typedef logic [15:0] adccal_coef_t;
   typedef enum logic [1:0] {
      ADCCAL_IDLE = 2'h1,
      ADCCAL_BUSY = 2'h2
   } adccal_mode_t;
endpackage : adccal_pkg

// File: logic/adccal_coef.sv
// temperature offset and current gain calibration coefficients behind an apb slave
`timescale 1ns/1ns
`include "adccal_regs.svh"
module adccal_coef #(
   parameter logic [15:0] TOFF_FACTORY = `ADCCAL_TOFF_RST,
   parameter logic [15:0] IGAIN_FACTORY = `ADCCAL_IGAIN_RST,
   parameter int IDLE_CYC = `ADCCAL_IDLE_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic conv_enable,
   input wire logic conv_idle,
   input wire logic toff_cal_done,
   input wire logic igain_cal_done,
   input wire logic [15:0] cal_result,
   output logic [15:0] toff_coef,
   output logic [15:0] igain_coef
);

   ////////////////////////////////////////////////////////////////////////////
   // idle qualification counter

   logic [15:0] idle_cnt_r, idle_cnt_nxt;
   logic open_r, open_nxt;
   logic drop_r, drop_nxt;
   adccal_pkg::adccal_coef_t toff_r, toff_nxt, igain_r, igain_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic ready_r, ready_nxt, err_r, err_nxt;
   logic acc, done, wr_toff, wr_igain;

   // address decode shared by the write strobes, the status clear and the read checks
   function automatic logic adccal_hit(input logic [31:0] a, input logic [31:0] r);
      return a == r;
   endfunction : adccal_hit

   // counter restarts whenever converter leaves enabled idle
   always_comb begin
      idle_cnt_nxt = idle_cnt_r;
      open_nxt = open_r;
      if (!(conv_enable && conv_idle)) begin
         idle_cnt_nxt = 16'h0000;
         open_nxt = 1'b0;
      end else if (!open_r) begin
         idle_cnt_nxt = idle_cnt_r + 16'h0001;
         if (idle_cnt_nxt >= IDLE_CYC[15:0]) open_nxt = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_cnt_r <= 16'h0000;
         open_r <= 1'b0;
      end else begin
         idle_cnt_r <= idle_cnt_nxt;
         open_r <= open_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // coefficient registers

   // request taken in the first access cycle; pready follows one cycle later
   assign acc = psel && penable && !ready_r;
   // writes land at the edge that samples pready high, while the master still holds them
   assign done = psel && penable && ready_r;
   assign wr_toff = done && pwrite && adccal_hit(paddr, `ADCCAL_TOFF_ADDR);
   assign wr_igain = done && pwrite && adccal_hit(paddr, `ADCCAL_IGAIN_ADDR);

   // calibration result has priority over a software write in the same cycle
   always_comb begin
      toff_nxt = toff_r;
      igain_nxt = igain_r;
      drop_nxt = drop_r;
      if (wr_toff && open_r) toff_nxt = pwdata[15:0];
      if (wr_igain && open_r) igain_nxt = pwdata[15:0];
      if ((wr_toff || wr_igain) && !open_r) drop_nxt = 1'b1;
      if (toff_cal_done) toff_nxt = cal_result;
      if (igain_cal_done) igain_nxt = cal_result;
      if (acc && !pwrite && adccal_hit(paddr, `ADCCAL_STAT_ADDR)) drop_nxt = 1'b0;
      if ((wr_toff || wr_igain) && !open_r) drop_nxt = 1'b1; // set wins over clear
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         toff_r <= TOFF_FACTORY;
         igain_r <= IGAIN_FACTORY;
         drop_r <= 1'b0;
      end else begin
         toff_r <= toff_nxt;
         igain_r <= igain_nxt;
         drop_r <= drop_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb answer

   // unmapped addresses answer with pslverr and zero data
   always_comb begin
      ready_nxt = acc;
      err_nxt = 1'b0;
      rdata_nxt = 32'h0000_0000;
      if (acc) begin
         unique case (paddr)
            `ADCCAL_TOFF_ADDR: rdata_nxt = {16'h0000, toff_r};
            `ADCCAL_IGAIN_ADDR: rdata_nxt = {16'h0000, igain_r};
            `ADCCAL_STAT_ADDR: rdata_nxt = {28'h0000000, drop_r, conv_idle,
                                            conv_enable, open_r};
            default: err_nxt = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_r <= 32'h0000_0000;
         ready_r <= 1'b0;
         err_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         ready_r <= ready_nxt;
         err_r <= err_nxt;
      end
   end

   assign prdata = rdata_r;
   assign pready = ready_r;
   assign pslverr = err_r;
   assign toff_coef = toff_r;
   assign igain_coef = igain_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // shadow count of enabled idle cycles, kept apart from the gate logic so
   // that a slip in the gate counter cannot hide inside its own checker
   logic [15:0] chk_cnt_r, chk_cnt_nxt;

   // saturates instead of wrapping so a long idle spell never reads as short
   always_comb begin
      chk_cnt_nxt = chk_cnt_r;
      if (!(conv_enable && conv_idle)) begin
         chk_cnt_nxt = 16'h0000;
      end else if (chk_cnt_r != 16'hffff) begin
         chk_cnt_nxt = chk_cnt_r + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chk_cnt_r <= 16'h0000;
      end else begin
         chk_cnt_r <= chk_cnt_nxt;
      end
   end

   // status read strobe, as the clear of the sticky flag sees it
   logic stat_rd;
   assign stat_rd = acc && !pwrite && adccal_hit(paddr, `ADCCAL_STAT_ADDR);

   // address classes seen by the bus answer checks
   logic mapped, rd_toff, rd_igain;
   assign mapped = adccal_hit(paddr, `ADCCAL_TOFF_ADDR) || adccal_hit(paddr, `ADCCAL_IGAIN_ADDR)
      || adccal_hit(paddr, `ADCCAL_STAT_ADDR);
   assign rd_toff = acc && !pwrite && adccal_hit(paddr, `ADCCAL_TOFF_ADDR);
   assign rd_igain = acc && !pwrite && adccal_hit(paddr, `ADCCAL_IGAIN_ADDR);

   ////////////////////////////////////////////////////////////////////////////
   // write gate and coefficient checks

   // gate never opens before the full idle spell
   gate_open_a: assert property (open_r |-> chk_cnt_r >= IDLE_CYC[15:0])
      else $error("gate open before idle time");

   // gate opens no later than the full idle spell
   gate_timely_a: assert property (chk_cnt_r >= IDLE_CYC[15:0] |-> open_r)
      else $error("gate late after idle time");

   // leaving enabled idle closes the gate at the next edge
   gate_drop_a: assert property (!(conv_enable && conv_idle) |=> !open_r)
      else $error("gate stayed open after leaving idle");

   // an open gate stays open while the converter idles
   gate_hold_a: assert property (open_r && conv_enable && conv_idle |=> open_r)
      else $error("gate closed while still idle");

   // closed gate: offset write leaves the coefficient untouched
   closed_write_a: assert property (wr_toff && !open_r && !toff_cal_done
      |=> $stable(toff_r))
      else $error("offset changed by write while closed");

   // closed gate: gain write leaves the coefficient untouched
   closed_gain_a: assert property (wr_igain && !open_r && !igain_cal_done
      |=> $stable(igain_r))
      else $error("gain changed by write while closed");

   // every dropped write raises the sticky flag
   drop_flag_a: assert property ((wr_toff || wr_igain) && !open_r |=> drop_r)
      else $error("ignored write not flagged");

   // reading the status word clears the sticky flag
   stat_clear_a: assert property (stat_rd |=> !drop_r)
      else $error("drop flag not cleared by status read");

   // nothing but a status read clears the sticky flag
   drop_hold_a: assert property (drop_r && !stat_rd |=> drop_r)
      else $error("drop flag lost");

   // open offset write lands in the low half
   offset_write_a: assert property (wr_toff && open_r && !toff_cal_done
      |=> toff_r == $past(pwdata[15:0]))
      else $error("offset write lost");

   // open gain write lands in the low half
   gain_write_a: assert property (wr_igain && open_r && !igain_cal_done
      |=> igain_r == $past(pwdata[15:0]))
      else $error("gain write lost");

   // offset only moves on a write or a calibration
   offset_hold_a: assert property (!wr_toff && !toff_cal_done |=> $stable(toff_r))
      else $error("offset changed with no cause");

   // gain only moves on a write or a calibration
   gain_hold_a: assert property (!wr_igain && !igain_cal_done |=> $stable(igain_r))
      else $error("gain changed with no cause");

   // a finished offset calibration wins over a write in the same cycle
   offset_cal_a: assert property (toff_cal_done |=> toff_r == $past(cal_result))
      else $error("offset cal result not stored");

   // a finished gain calibration wins over a write in the same cycle
   gain_cal_a: assert property (igain_cal_done |=> igain_r == $past(cal_result))
      else $error("gain cal result not stored");

   // factory values stand right after reset
   reset_value_a: assert property ($rose(presetn) |-> toff_r == TOFF_FACTORY
      && igain_r == IGAIN_FACTORY)
      else $error("coefficients not factory values");

   ////////////////////////////////////////////////////////////////////////////
   // bus answer checks

   // the answer is a single registered cycle
   ready_pulse_a: assert property (acc |=> pready ##1 !pready)
      else $error("apb answer not one cycle");

   // no answer without a request taken the cycle before
   ready_source_a: assert property (pready |-> $past(acc))
      else $error("pready without a request");

   // between answers the bus reads zero and shows no error
   bus_quiet_a: assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
      else $error("read data outside answer");

   // coefficients are 16 bits, the upper half reads zero
   upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
      else $error("upper half not zero");

   // unmapped addresses answer with an error
   err_unmapped_a: assert property (acc && !mapped |=> pready && pslverr)
      else $error("unmapped address without error");

   // mapped addresses answer cleanly
   err_mapped_a: assert property (acc && mapped |=> !pslverr)
      else $error("mapped address answered with error");

   // offset read returns the value standing when the request was taken
   offset_read_a: assert property (rd_toff |=> prdata == {16'h0000, $past(toff_r)})
      else $error("offset read wrong");

   // gain read returns the value standing when the request was taken
   gain_read_a: assert property (rd_igain |=> prdata == {16'h0000, $past(igain_r)})
      else $error("gain read wrong");

   // status read shows flag, idle, enable and gate in the low nibble
   status_read_a: assert property (stat_rd
      |=> prdata[3:0] == $past({drop_r, conv_idle, conv_enable, open_r}))
      else $error("status word wrong");

   // main scenarios: gate opening, an open write, a dropped write, calibrations
   cov_open_c: cover property (!open_r ##1 open_r);
   cov_wr_c: cover property (wr_toff && open_r);
   cov_drop_c: cover property (wr_igain && !open_r);
   cov_cal_c: cover property (toff_cal_done ##1 igain_cal_done);
   cov_err_c: cover property (acc && !mapped);

endmodule : adccal_coef

// File: testbench/adccal_coef_tb.sv
// self-checking bench for the calibration coefficient block
`timescale 1ns/1ns
`include "adccal_regs.svh"
module adccal_coef_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic conv_enable, conv_idle, toff_cal_done, igain_cal_done;
   logic [31:0] paddr, pwdata, prdata, rd, d;
   logic [15:0] cal_result, toff_coef, igain_coef, v;
   int bad_count = 0;
   int tests_run = 0;
   int cyc = 0;
   // short idle gate keeps the run brief; expectations follow it
   adccal_coef #(.IDLE_CYC(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_enable(conv_enable), .conv_idle(conv_idle),
      .toff_cal_done(toff_cal_done), .igain_cal_done(igain_cal_done),
      .cal_result(cal_result), .toff_coef(toff_coef), .igain_coef(igain_coef));
   ////////////////////////////////////////////////////////////////////////////////
   // clock and hang guard, far above the hundred or so cycles needed
   initial begin
      pclk = 0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         test_done();
      end
   end
   task test_done;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : test_done
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // expected read value of a coefficient word: low half kept, upper half zero
   function automatic logic [31:0] exp_coef(input logic [31:0] w);
      return {16'h0000, w[15:0]};
   endfunction : exp_coef
   // one apb transfer, request held until pready is sampled high
   task apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         bad_count++;
         $display("MISMATCH pready expected 1 seen %b", pready);
      end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {psel, penable, pwrite, conv_enable, conv_idle, toff_cal_done, igain_cal_done} = '0;
      paddr = '0;
      pwdata = '0;
      cal_result = '0;
      presetn = 0;
      void'($urandom(62));
      repeat (4) @(posedge pclk);
      presetn <= 1;
      chk("toff reset", 32'h0000_8000, {16'h0000, toff_coef});
      chk("igain reset", 32'h0000_5555, {16'h0000, igain_coef});
      // gate closed, then enabled too briefly: writes must be dropped
      apb(1'b1, `ADCCAL_TOFF_ADDR, 32'hffff_1234);
      apb(1'b0, `ADCCAL_TOFF_ADDR, 32'h0);
      chk("toff closed", 32'h0000_8000, rd);
      apb(1'b0, `ADCCAL_STAT_ADDR, 32'h0);
      chk("drop flag", 32'h1, {31'h0, rd[3]});
      conv_enable <= 1;
      conv_idle <= 1;
      apb(1'b1, `ADCCAL_IGAIN_ADDR, 32'h0000_0001);
      apb(1'b0, `ADCCAL_IGAIN_ADDR, 32'h0);
      chk("igain early", 32'h0000_5555, rd);
      repeat (10) @(posedge pclk);
      apb(1'b0, `ADCCAL_STAT_ADDR, 32'h0);
      chk("status open", 32'h0000_000f, rd);
      apb(1'b0, `ADCCAL_STAT_ADDR, 32'h0);
      chk("status clear", 32'h0000_0007, rd);
      // gate open: random and all-ones words, upper half ignored
      for (int i = 0; i < 6; i++) begin
         d = (i == 0) ? 32'hffff_ffff : $urandom;
         apb(1'b1, (i % 2) ? `ADCCAL_IGAIN_ADDR : `ADCCAL_TOFF_ADDR, d);
         apb(1'b0, (i % 2) ? `ADCCAL_IGAIN_ADDR : `ADCCAL_TOFF_ADDR, 32'h0);
         chk("coef rw", exp_coef(d), rd);
      end
      // calibration results overwrite the coefficients
      v = 16'($urandom);
      @(posedge pclk);
      cal_result <= v;
      toff_cal_done <= 1;
      @(posedge pclk);
      toff_cal_done <= 0;
      igain_cal_done <= 1;
      cal_result <= ~v;
      @(posedge pclk);
      igain_cal_done <= 0;
      @(posedge pclk);
      chk("toff cal", {16'h0000, v}, {16'h0000, toff_coef});
      chk("igain cal", {16'h0000, ~v}, {16'h0000, igain_coef});
      apb(1'b0, 32'hffff_0550, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, er});
      chk("unmapped data", 32'h0, rd);
      // losing enable closes the gate at once
      conv_enable <= 0;
      apb(1'b1, `ADCCAL_TOFF_ADDR, 32'h0000_0f0f);
      apb(1'b0, `ADCCAL_TOFF_ADDR, 32'h0);
      chk("toff disabled", {16'h0000, v}, rd);
      test_done();
   end
endmodule : adccal_coef_tb
